// *** rtl/rmsc_map.svh ***
`ifndef RMSC_MAP_SVH
`define RMSC_MAP_SVH
// Register addresses on the control link
`define RMSC_ADDR_MODE 8'hc1
`define RMSC_ADDR_AUDIO 8'hc2
`define RMSC_ADDR_TONE 8'hc3
// Writable bits of each register; reserved bits are stored as zero
`define RMSC_MODE_WMASK 16'hfefb
`define RMSC_AUDIO_WMASK 16'h1f3f
`define RMSC_TONE_WMASK 16'hf83f
// Mode control fields
`define RMSC_MODE_SEL_LSB 0
`define RMSC_MODEM_LSB 3
`define RMSC_SYNC_A_BIT 5
`define RMSC_SYNC_B_BIT 6
`define RMSC_SYNC_B_INV_BIT 7
`define RMSC_SUB_LSB 9
`define RMSC_AUDIO_TONE_BIT 12
`define RMSC_VB_LSB 13
`define RMSC_VOICE_BIT 15
// Audio and sub-audio control fields
`define RMSC_TONE_NUM_LSB 0
`define RMSC_SPECIAL_LSB 8
`define RMSC_EMPH_BIT 10
`define RMSC_VFILT_LSB 11
`define RMSC_TONE_NUM_MAX 6'h27
// Transmit tone fields
`define RMSC_DIAL_LSB 0
`define RMSC_SINGLE_BIT 4
`define RMSC_TWIST_BIT 5
`define RMSC_SELCALL_LSB 11
// Host register offsets (APB byte addresses)
`define RMSC_APB_CMD 12'h000
`define RMSC_APB_DATA 12'h004
`define RMSC_APB_STAT 12'h008
`define RMSC_APB_MODE 12'h00c
`define RMSC_APB_AUDIO 12'h010
`define RMSC_APB_TONE 12'h014
`define RMSC_APB_DEV 12'h018
// Device reset value of every control register
`define RMSC_REG_RESET 16'h0000
`endif

// *** rtl/rmsc_pkg.sv ***
package rmsc_pkg;
   typedef enum logic [1:0] {
      RMSC_IDLE, RMSC_RX, RMSC_TX, RMSC_SAVE
   } rmsc_mode_t;
   typedef enum logic [1:0] {
      RMSC_NO_MODEM, RMSC_SLOW, RMSC_FAST, RMSC_BOTH
   } rmsc_modem_t;
endpackage : rmsc_pkg

// *** rtl/rmsc_if.sv ***
`timescale 1ns/1ps
interface rmsc_if;
   logic wr;
   logic [7:0] addr;
   logic [15:0] wdata;
   logic sync_found;
   modport ctrl (output wr, output addr, output wdata, input sync_found);
   modport dev (input wr, input addr, input wdata, output sync_found);
endinterface : rmsc_if

// *** rtl/rmsc_device.sv ***
`timescale 1ns/1ps
`include "rmsc_map.svh"
// Behaviour
// - Two-bit field picks idle, receive, transmit, save
// - Host enables one signal per band
// - Receive searches all enabled signals in parallel
// - Transmit starts on enable; data loaded first
// - Modem field selects no modem, slow, fast
// - Modem field change starts or stops data
// - One bit enables each of the three frame sync searches
// - Host clears sync bits when sending data
// - Sub-audio field selects code and tone squelch
// - Audio tone in transmit only when modem and voice-band idle
// - Voice-band field selects selcall or dialling
// - Voice enable routes audio path
// - Voice path suppressed by other signals
// - Cleared enable returns band to phase one
// - Detection gated by threshold with hysteresis
// - Frame sync disables selcall until rewritten
// - Tone number 0 to 39 picks squelch tone
// - Special field: turn-off tone or clone mode
// - Voice filter field and emphasis bit
// - Five-bit field picks selcall tone
// - Twist sends lower tone 2 dB down
// - Four-bit dial code, optional single tone
// - Save mode forces block power enables off
module rmsc_device
   import rmsc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control link
   rmsc_if.dev link,
   // Detector inputs from signal processing
   input wire logic frame_sync_b_seen,
   input wire logic [1:0] band_level_above,
   // Mode and power
   output rmsc_mode_t mode,
   output logic power_force_off,
   // Transmit enables
   output logic tx_modem_slow,
   output logic tx_modem_fast,
   output logic tx_tone_squelch,
   output logic tx_code_squelch,
   output logic tx_code_squelch_inverse,
   output logic tx_turn_off_tone,
   output logic tx_selcall,
   output logic tx_dial,
   output logic tx_audio_tone,
   output logic [4:0] tx_selcall_tone,
   output logic [3:0] tx_dial_tone_code,
   output logic tx_dial_single,
   output logic tx_dial_twist,
   // Receive search enables
   output logic rx_modem_slow_enable,
   output logic rx_modem_fast_enable,
   output logic frame_sync_a_detect,
   output logic frame_sync_b_detect,
   output logic frame_sync_b_inverse_detect,
   output logic rx_tone_squelch,
   output logic rx_code_squelch,
   output logic rx_code_squelch_inverse,
   output logic rx_clone,
   output logic rx_selcall,
   output logic rx_audio_tone,
   output logic [1:0] band_restart,
   // Shared audio settings
   output logic voice_path_on,
   output logic [5:0] tone_squelch_number,
   output logic [1:0] voice_filter,
   output logic emphasis_on
);
   logic [15:0] mode_ff, nxt_mode;
   logic [15:0] audio_ff, nxt_audio;
   logic [15:0] tone_ff, nxt_tone;
   logic selcall_hold_ff, nxt_selcall_hold;
   logic [1:0] restart_ff, nxt_restart;
   logic is_tx, is_rx;
   logic [1:0] modem_f, vb_f, sp_f;
   logic [2:0] sub_f;
   logic in_ok;
   logic wr_mode;
   logic [2:0] sync_on, sub_on;
   logic tx_voice_busy, rx_voice_busy;

   // One search enable per frame sync pattern and per sub-audio code;
   // built from the registers and band_level_above, not is_rx, so no path loops through the decode
   for (genvar g = 0; g < 3; g++) begin : g_search
      assign sync_on[g] = mode_ff[`RMSC_MODE_SEL_LSB +: 2] == RMSC_RX &&
         mode_ff[`RMSC_MODEM_LSB +: 2] != RMSC_NO_MODEM &&
         mode_ff[`RMSC_SYNC_A_BIT + g];
      assign sub_on[g] = mode_ff[`RMSC_MODE_SEL_LSB +: 2] == RMSC_RX &&
         mode_ff[`RMSC_SUB_LSB + g] &&
         band_level_above[0];
   end

   always_comb begin
      wr_mode = link.wr && link.addr == `RMSC_ADDR_MODE;
      nxt_mode = mode_ff;
      nxt_audio = audio_ff;
      nxt_tone = tone_ff;
      // Reserved bits are dropped so stray host bits cannot enable anything
      if (wr_mode) begin
         nxt_mode = link.wdata & `RMSC_MODE_WMASK;
      end
      if (link.wr && link.addr == `RMSC_ADDR_AUDIO) begin
         nxt_audio = link.wdata & `RMSC_AUDIO_WMASK;
      end
      if (link.wr && link.addr == `RMSC_ADDR_TONE) begin
         nxt_tone = link.wdata & `RMSC_TONE_WMASK;
      end
      // Hold off selcall after a frame sync until voice bits are rewritten
      nxt_selcall_hold = selcall_hold_ff;
      if (wr_mode) begin
         nxt_selcall_hold = 1'b0;
      end
      if (frame_sync_b_seen && is_rx) begin
         nxt_selcall_hold = 1'b1;
      end
      // A band that loses any of its set enables returns to its first phase
      nxt_restart[0] = wr_mode &&
         (mode_ff[`RMSC_SUB_LSB +: 3] & ~link.wdata[`RMSC_SUB_LSB +: 3])
         != 3'b000;
      nxt_restart[1] = wr_mode &&
         ((mode_ff[`RMSC_VB_LSB +: 2] & ~link.wdata[`RMSC_VB_LSB +: 2])
         != 2'b00 ||
         (mode_ff[`RMSC_MODEM_LSB +: 2] & ~link.wdata[`RMSC_MODEM_LSB +: 2])
         != 2'b00);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= `RMSC_REG_RESET;
         audio_ff <= `RMSC_REG_RESET;
         tone_ff <= `RMSC_REG_RESET;
         selcall_hold_ff <= 1'b0;
         restart_ff <= 2'b00;
      end else begin
         mode_ff <= nxt_mode;
         audio_ff <= nxt_audio;
         tone_ff <= nxt_tone;
         selcall_hold_ff <= nxt_selcall_hold;
         restart_ff <= nxt_restart;
      end
   end

   always_comb begin
      mode = rmsc_mode_t'(mode_ff[`RMSC_MODE_SEL_LSB +: 2]);
      is_tx = mode == RMSC_TX;
      is_rx = mode == RMSC_RX;
      // Save mode keeps every register; only block power is forced down
      power_force_off = mode == RMSC_SAVE;
      modem_f = mode_ff[`RMSC_MODEM_LSB +: 2];
      sub_f = mode_ff[`RMSC_SUB_LSB +: 3];
      vb_f = mode_ff[`RMSC_VB_LSB +: 2];
      sp_f = audio_ff[`RMSC_SPECIAL_LSB +: 2];
      // An out-of-range number silences the transmit tone squelch only
      in_ok = audio_ff[`RMSC_TONE_NUM_LSB +: 6] <= `RMSC_TONE_NUM_MAX;
      // Transmit follows register bits directly, so it starts on the write
      tx_modem_slow = is_tx && modem_f == RMSC_SLOW;
      tx_modem_fast = is_tx && modem_f == RMSC_FAST;
      tx_tone_squelch = is_tx && sub_f == 3'b100 && in_ok;
      tx_turn_off_tone = is_tx && sp_f == 2'b01 && sub_f == 3'b010;
      tx_code_squelch = is_tx && sub_f == 3'b010 && !tx_turn_off_tone;
      tx_code_squelch_inverse = is_tx && sub_f == 3'b001;
      // Reserved transmit codes decode to no signal rather than a guess
      tx_selcall = is_tx && vb_f == 2'b01;
      tx_dial = is_tx && vb_f == 2'b10;
      tx_audio_tone = is_tx && mode_ff[`RMSC_AUDIO_TONE_BIT] &&
         vb_f == 2'b00 && modem_f == 2'b00;
      tx_selcall_tone = tone_ff[`RMSC_SELCALL_LSB +: 5];
      tx_dial_tone_code = tone_ff[`RMSC_DIAL_LSB +: 4];
      tx_dial_single = tone_ff[`RMSC_SINGLE_BIT];
      tx_dial_twist = tone_ff[`RMSC_TWIST_BIT];
      // Receive searches every enabled type at once
      // Code 11 runs both rate searches side by side
      rx_modem_slow_enable = is_rx && modem_f[0];
      rx_modem_fast_enable = is_rx && modem_f[1];
      frame_sync_a_detect = sync_on[0];
      frame_sync_b_detect = sync_on[1];
      frame_sync_b_inverse_detect = sync_on[2];
      // Level gating: the detectors report hysteresis-filtered level flags
      rx_tone_squelch = sub_on[2];
      rx_code_squelch = sub_on[1];
      rx_code_squelch_inverse = sub_on[0];
      rx_clone = is_rx && sp_f == 2'b11 && band_level_above[0];
      // Selcall stays off after a frame sync until the host rewrites mode
      rx_selcall = is_rx && vb_f == 2'b01 && !selcall_hold_ff &&
         band_level_above[1];
      rx_audio_tone = is_rx && mode_ff[`RMSC_AUDIO_TONE_BIT];
      // One-cycle pulse sends the band's detector back to its first phase
      band_restart = restart_ff;
      // Signalling owns the modulator in transmit; voice waits its turn
      tx_voice_busy = modem_f != 2'b00 || vb_f != 2'b00 ||
         mode_ff[`RMSC_AUDIO_TONE_BIT];
      rx_voice_busy = mode_ff[`RMSC_AUDIO_TONE_BIT];
      voice_path_on = mode_ff[`RMSC_VOICE_BIT] &&
         (is_tx && !tx_voice_busy || is_rx && !rx_voice_busy);
      tone_squelch_number = audio_ff[`RMSC_TONE_NUM_LSB +: 6];
      voice_filter = audio_ff[`RMSC_VFILT_LSB +: 2];
      emphasis_on = audio_ff[`RMSC_EMPH_BIT];
   end

   assign link.sync_found = selcall_hold_ff;
endmodule : rmsc_device

// *** rtl/rmsc_ctrl.sv ***
`timescale 1ns/1ps
`include "rmsc_map.svh"
// Host side: software posts link writes through an APB slave
module rmsc_ctrl
   import rmsc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control link
   rmsc_if.ctrl link
);
   logic [7:0] addr_ff, nxt_addr;
   logic [15:0] data_ff, nxt_data;
   logic wr_ff, nxt_wr;
   logic [15:0] mode_sh_ff, nxt_mode_sh;
   logic [15:0] audio_sh_ff, nxt_audio_sh;
   logic [15:0] tone_sh_ff, nxt_tone_sh;
   logic acc, we, hit;

   always_comb begin
      acc = psel && penable;
      we = acc && pwrite;
      hit = paddr == `RMSC_APB_CMD || paddr == `RMSC_APB_DATA ||
         paddr == `RMSC_APB_STAT || paddr == `RMSC_APB_MODE ||
         paddr == `RMSC_APB_AUDIO || paddr == `RMSC_APB_TONE;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_wr = 1'b0;
      nxt_mode_sh = mode_sh_ff;
      nxt_audio_sh = audio_sh_ff;
      nxt_tone_sh = tone_sh_ff;
      if (we && paddr == `RMSC_APB_DATA) begin
         nxt_data = pwdata[15:0];
      end
      // Writing the address word launches one link write with held data
      if (we && paddr == `RMSC_APB_CMD) begin
         nxt_addr = pwdata[7:0];
         nxt_wr = 1'b1;
         if (pwdata[7:0] == `RMSC_ADDR_MODE) nxt_mode_sh = data_ff;
         if (pwdata[7:0] == `RMSC_ADDR_AUDIO) nxt_audio_sh = data_ff;
         if (pwdata[7:0] == `RMSC_ADDR_TONE) nxt_tone_sh = data_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_ff <= 8'h00;
         data_ff <= 16'h0000;
         wr_ff <= 1'b0;
         mode_sh_ff <= `RMSC_REG_RESET;
         audio_sh_ff <= `RMSC_REG_RESET;
         tone_sh_ff <= `RMSC_REG_RESET;
      end else begin
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         wr_ff <= nxt_wr;
         mode_sh_ff <= nxt_mode_sh;
         audio_sh_ff <= nxt_audio_sh;
         tone_sh_ff <= nxt_tone_sh;
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         `RMSC_APB_DATA: prdata = {16'h0000, data_ff};
         `RMSC_APB_STAT: prdata = {30'h0, link.sync_found, wr_ff};
         `RMSC_APB_MODE: prdata = {16'h0000, mode_sh_ff};
         `RMSC_APB_AUDIO: prdata = {16'h0000, audio_sh_ff};
         `RMSC_APB_TONE: prdata = {16'h0000, tone_sh_ff};
         `RMSC_APB_CMD: prdata = {24'h0, addr_ff};
         default: prdata = 32'h0000_0000;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = acc && !hit;
   assign link.wr = wr_ff;
   assign link.addr = addr_ff;
   assign link.wdata = data_ff;
endmodule : rmsc_ctrl

// *** test/rmsc_chk.sv ***
`timescale 1ns/1ps
`include "rmsc_map.svh"
// Watches the control link between host side and device
module rmsc_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control link
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic sync_found
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A longer strobe would write the same register twice
   a_wr_one_cycle: assert property (
      wr |=> !wr && $stable(wdata)) else $error("link strobe too long");
   a_addr_held: assert property (
      $changed(addr) |-> wr) else $error("link address moved alone");
   // Only a mode write may release the selcall hold
   a_sync_cleared: assert property (
      $fell(sync_found) |-> $past(wr && addr == `RMSC_ADDR_MODE))
      else $error("selcall hold dropped without mode write");
   a_hold_steady: assert property (
      sync_found && !(wr && addr == `RMSC_ADDR_MODE) |=> sync_found)
      else $error("selcall hold dropped on its own");
   // Data must settle before the strobe that carries it
   a_data_settled: assert property (
      wr |-> $stable(wdata)) else $error("link data moved with strobe");
   a_reset_quiet: assert property (
      $rose(presetn) |-> !sync_found && !wr)
      else $error("link busy right after reset");
   c_sync_set: cover property ($rose(sync_found));
endmodule : rmsc_chk

// *** test/test_radio_mode_signalling_control.sv ***
`timescale 1ns/1ps
`include "rmsc_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   errors++; $display("unexpected at %0t got %h want %h", $time, a, b); \
   end end
module test_radio_mode_signalling_control
   import rmsc_pkg::*;
();
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, se;
   logic fsb = 1'b0;
   logic [1:0] bla = 2'b11;
   rmsc_mode_t mode;
   logic power_force_off, tx_modem_slow, tx_modem_fast, tx_tone_squelch;
   logic tx_code_squelch, tx_code_squelch_inverse, tx_turn_off_tone;
   logic tx_selcall, tx_dial, tx_audio_tone, tx_dial_single, tx_dial_twist;
   logic [4:0] tx_selcall_tone;
   logic [3:0] tx_dial_tone_code;
   logic rx_modem_slow_enable, rx_modem_fast_enable, frame_sync_a_detect;
   logic frame_sync_b_detect, frame_sync_b_inverse_detect, rx_tone_squelch;
   logic rx_code_squelch, rx_code_squelch_inverse, rx_clone, rx_selcall;
   logic rx_audio_tone, voice_path_on, emphasis_on;
   logic [5:0] tone_squelch_number;
   logic [1:0] voice_filter;
   logic [1:0] band_restart;
   int errors = 0;
   int samples_checked = 0;
   int i;
   int sb[5] = '{3, 4, 12, 13, 14};
   logic [15:0] tw[2] = '{16'hf835, 16'h5807};
   wire [2:0] syn = {frame_sync_b_inverse_detect, frame_sync_b_detect,
      frame_sync_a_detect};
   wire [2:0] rxs = {rx_tone_squelch, rx_code_squelch, rx_code_squelch_inverse};
   wire [2:0] txs = {tx_tone_squelch, tx_code_squelch, tx_code_squelch_inverse};
   wire [4:0] txv = {tx_dial, tx_selcall, tx_audio_tone, tx_modem_fast,
      tx_modem_slow};
   wire [1:0] rxm = {rx_modem_fast_enable, rx_modem_slow_enable};
   wire [10:0] txt = {tx_selcall_tone, tx_dial_twist, tx_dial_single,
      tx_dial_tone_code};

   always #10 pclk = ~pclk;

   rmsc_if rmsc_if_i ();
   rmsc_ctrl rmsc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .link(rmsc_if_i));
   rmsc_device rmsc_device_i (.pclk, .presetn, .link(rmsc_if_i),
      .frame_sync_b_seen(fsb), .band_level_above(bla), .mode,
      .power_force_off, .tx_modem_slow, .tx_modem_fast, .tx_tone_squelch,
      .tx_code_squelch, .tx_code_squelch_inverse, .tx_turn_off_tone,
      .tx_selcall, .tx_dial, .tx_audio_tone, .tx_selcall_tone,
      .tx_dial_tone_code, .tx_dial_single, .tx_dial_twist,
      .rx_modem_slow_enable, .rx_modem_fast_enable, .frame_sync_a_detect,
      .frame_sync_b_detect, .frame_sync_b_inverse_detect, .rx_tone_squelch,
      .rx_code_squelch, .rx_code_squelch_inverse, .rx_clone, .rx_selcall,
      .rx_audio_tone, .band_restart, .voice_path_on, .tone_squelch_number,
      .voice_filter, .emphasis_on);
   rmsc_chk rmsc_chk_i (.pclk, .presetn, .wr(rmsc_if_i.wr),
      .addr(rmsc_if_i.addr), .wdata(rmsc_if_i.wdata),
      .sync_found(rmsc_if_i.sync_found));

   task close_out;
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // Idle cycle before each setup keeps one assignment per time step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         errors++;
         close_out;
      end
   endtask : apb

   // Data then command; register shows one edge after the command
   task lw(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, `RMSC_APB_DATA, {16'h0000, d});
      apb(1'b1, `RMSC_APB_CMD, {24'h000000, a});
      repeat (3) @(posedge pclk);
      #1;
   endtask : lw

   // Mode write, then look one edge later while the restart pulse stands
   task lw_edge(input logic [15:0] d);
      apb(1'b1, `RMSC_APB_DATA, {16'h0000, d});
      apb(1'b1, `RMSC_APB_CMD, {24'h000000, `RMSC_ADDR_MODE});
      @(posedge pclk);
      #1;
   endtask : lw_edge

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      `CHK(mode, RMSC_IDLE)
      `CHK(voice_path_on, 1'b0)
      for (i = 0; i < 4; i++) begin
         lw(`RMSC_ADDR_MODE, 16'(i));
         `CHK(mode, rmsc_mode_t'(i))
         `CHK(power_force_off, i == 3)
      end
      for (i = 1; i < 8; i++) begin
         lw(`RMSC_ADDR_MODE, 16'h0001 | 16'(i << 5) | 16'((i % 3 + 1) << 3));
         `CHK(rxm, 2'(i % 3 + 1))
         `CHK(syn, 3'(i))
      end
      for (i = 0; i < 8; i++) begin
         lw(`RMSC_ADDR_MODE, 16'h0001 | 16'(i << 9));
         `CHK(rxs, 3'(i))
      end
      lw_edge(16'h0401);
      `CHK(band_restart, 2'b01)
      lw_edge(16'h0401);
      `CHK(band_restart, 2'b00)
      // Tone number goes in before any transmit enable
      lw(`RMSC_ADDR_AUDIO, 16'h0027);
      for (i = 0; i < 3; i++) begin
         lw(`RMSC_ADDR_MODE, 16'h0002 | 16'(1 << (i + 9)));
         `CHK(txs, 3'(1 << i))
      end
      `CHK(tone_squelch_number, 6'h27)
      lw(`RMSC_ADDR_AUDIO, 16'h0028);
      `CHK(tx_tone_squelch, 1'b0)
      lw(`RMSC_ADDR_AUDIO, 16'h0100);
      lw(`RMSC_ADDR_MODE, 16'h0402);
      `CHK({tx_turn_off_tone, tx_code_squelch}, 2'b10)
      lw(`RMSC_ADDR_MODE, 16'h8002);
      `CHK(voice_path_on, 1'b1)
      for (i = 0; i < 5; i++) begin
         lw(`RMSC_ADDR_MODE, 16'h8002 | 16'(1 << sb[i]));
         `CHK(voice_path_on, 1'b0)
         `CHK(txv, 5'(1 << i))
      end
      lw(`RMSC_ADDR_MODE, 16'h1012);
      `CHK({tx_audio_tone, tx_modem_fast}, 2'b01)
      lw(`RMSC_ADDR_MODE, 16'h8001);
      `CHK(voice_path_on, 1'b1)
      lw(`RMSC_ADDR_MODE, 16'h9001);
      `CHK({voice_path_on, rx_audio_tone}, 2'b01)
      for (i = 0; i < 6; i++) begin
         lw(`RMSC_ADDR_AUDIO, 16'(i << 10));
         `CHK({voice_filter, emphasis_on}, 3'(i))
      end
      lw(`RMSC_ADDR_AUDIO, 16'h0300);
      lw(`RMSC_ADDR_MODE, 16'h0801);
      `CHK(rx_clone, 1'b1)
      for (i = 0; i < 2; i++) begin
         lw(`RMSC_ADDR_TONE, tw[i]);
         `CHK(txt, {tw[i][15:11], tw[i][5:0]})
      end
      lw(`RMSC_ADDR_MODE, 16'h2001);
      `CHK(rx_selcall, 1'b1)
      @(posedge pclk);
      fsb <= 1'b1;
      @(posedge pclk);
      fsb <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      `CHK({rx_selcall, rmsc_if_i.sync_found}, 2'b01)
      apb(1'b0, `RMSC_APB_STAT, 32'h0);
      `CHK(rd, 32'h0000_0002)
      lw(`RMSC_ADDR_MODE, 16'h2001);
      `CHK(rx_selcall, 1'b1)
      @(posedge pclk);
      bla <= 2'b01;
      @(posedge pclk);
      #1;
      `CHK(rx_selcall, 1'b0)
      @(posedge pclk);
      bla <= 2'b11;
      apb(1'b0, `RMSC_APB_DEV, 32'h0);
      `CHK({se, rd}, {1'b1, 32'h0})
      apb(1'b0, `RMSC_APB_MODE, 32'h0);
      `CHK(rd[15:0], 16'h2001)
      lw_edge(16'h0001);
      `CHK(band_restart, 2'b10)
      close_out;
   end
endmodule : test_radio_mode_signalling_control
